/* rtl/rsirq_alert.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// FIFO threshold compare
// ----------------------------------------
module rsirq_alert
    import rsirq_pkg::*;
#(
    parameter int DEPTH = RSIRQ_FIFO_DEPTH
) (
    input wire logic [6:0] fill_in,
    input wire logic [7:0] threshold_in,
    output logic near_full_out,
    output logic near_empty_out
);
    logic [7:0] room;

    // Seven-bit fill count limits the depth
    if (DEPTH < 1 || DEPTH > 127) begin : g_depth_check
        $error("DEPTH out of range");
    end

    // Free room can be negative only if fill exceeds depth; clamp it
    always_comb begin
        if ({1'b0, fill_in} > 8'(DEPTH)) begin
            room = 8'h00;
        end else begin
            room = 8'(DEPTH) - {1'b0, fill_in};
        end
        near_full_out = (room <= threshold_in); // RULE19
        near_empty_out = ({1'b0, fill_in} <= threshold_in); // RULE20
    end

endmodule : rsirq_alert
`default_nettype wire

/* rtl/rsirq_pkg.sv */
`default_nettype none
package rsirq_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] RSIRQ_OFS_FILL = 8'h04;
    localparam logic [7:0] RSIRQ_OFS_SEC = 8'h05;
    localparam logic [7:0] RSIRQ_OFS_EN = 8'h06;
    localparam logic [7:0] RSIRQ_OFS_RQ = 8'h07;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RSIRQ_RST_FILL = 8'h00;
    localparam logic [7:0] RSIRQ_RST_SEC = 8'h60;
    localparam logic [5:0] RSIRQ_RST_EN = 6'h00;
    localparam logic [5:0] RSIRQ_RST_RQ = 6'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int RSIRQ_SET_SELECT_BIT = 7;
    localparam int RSIRQ_TIMER_BIT = 7;
    localparam int RSIRQ_NVM_BIT = 6;
    localparam int RSIRQ_CHECKSUM_BIT = 5;
    localparam int RSIRQ_SRC_TIMER = 5;
    localparam int RSIRQ_SRC_TX = 4;
    localparam int RSIRQ_SRC_RX = 3;
    localparam int RSIRQ_SRC_IDLE = 2;
    localparam int RSIRQ_SRC_HIGH = 1;
    localparam int RSIRQ_SRC_LOW = 0;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int RSIRQ_FIFO_DEPTH = 64;
    localparam int RSIRQ_SRC_COUNT = 6;

    // Processor access, one cycle strobes
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsirq_bus_s;

    // Events from the rest of the reader, one cycle pulses except the levels timer_running, nvm_busy, checksum_busy, last_bits
    typedef struct packed {
        logic fifo_push;
        logic fifo_pop;
        logic fifo_flush;
        logic timer_running;
        logic nvm_busy;
        logic checksum_busy;
        logic [2:0] last_bits;
        logic timer_zero;
        logic tx_done;
        logic rx_done;
        logic cmd_idle_return;
        logic cmd_unknown;
    } rsirq_evt_s;

endpackage : rsirq_pkg
`default_nettype wire

/* rtl/rsirq_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1 - Fill count of the 64-byte FIFO in bits 6..0, bit 7 reads zero.
// RULE2 - Each FIFO write adds one to the count, each read subtracts one.
// RULE3 - Secondary bit 7 is one while the timer runs.
// RULE4 - Secondary bit 6 is one once nonvolatile programming has finished.
// RULE5 - Secondary bit 5 is one once the checksum calculation has finished.
// RULE6 - Bits 2..0 give valid bits of the last byte; bits 4,3 read zero.
// RULE7 - Secondary status reads 60h after reset.
// RULE8 - Enable write: bit 7 set sets marked bits 5..0, else clears them.
// RULE9 - Enable bits 5..0 pass timer, tx, rx, idle, high, low requests.
// RULE10 - Request write: bit 7 set sets marked bits 5..0, else clears them.
// RULE11 - Timer reaching zero sets request bit 5.
// RULE12 - Transmit, checksum or nonvolatile write completion sets request bit 4; the code sets it from tx_done only.
// RULE13 - Receiver finishing a reception sets request bit 3.
// RULE14 - Command ending normally or unknown command start sets request bit 2.
// RULE15 - Processor-started idle command does not set request bit 2.
// RULE16 - Near-full alert becoming set sets request bit 1.
// RULE17 - Near-empty alert becoming set sets request bit 0.
// RULE18 - Alert request flags stay latched until cleared by a processor write.
// RULE19 - Near-full is one when 64 minus fill is at most the threshold.
// RULE20 - Near-empty is one when fill is at most the threshold.
// RULE21 - Summary bit shows any enabled request pending.
// RULE22 - Interrupt output is high while any request has its enable set.
module rsirq_regs
    import rsirq_pkg::*;
#(
    parameter int DEPTH = RSIRQ_FIFO_DEPTH
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire rsirq_bus_s bus_in,
    input wire rsirq_evt_s evt_in,
    input wire logic [7:0] fifo_threshold_in,
    input wire logic processor_idle_cmd_in,
    output logic [7:0] rdata_out,
    output logic irq_out,
    output logic irq_summary_out,
    output logic fifo_near_full_out,
    output logic fifo_near_empty_out
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [6:0] fifo_fill_count_reg;
    logic [7:0] secondary_flags_reg;
    logic [5:0] irq_enable_mask_reg;
    logic [5:0] irq_request_flags_reg;
    logic near_full_reg;
    logic near_empty_reg;
    logic near_full_now;
    logic near_empty_now;
    logic [5:0] hw_set;
    logic [5:0] irq_request_flags_next;
    logic [5:0] irq_enable_mask_next;
    logic wr_en;
    logic wr_rq;

    // Seven-bit fill count limits the depth
    if (DEPTH < 1 || DEPTH > 127) begin : g_depth_check
        $error("DEPTH out of range");
    end

    // Marked-bit update shared by both set/clear registers
    function automatic logic [5:0] rsirq_mark(input logic [5:0] cur, input logic [7:0] wd);
        if (wd[RSIRQ_SET_SELECT_BIT]) begin
            rsirq_mark = cur | wd[5:0];
        end else begin
            rsirq_mark = cur & ~wd[5:0];
        end
    endfunction : rsirq_mark

    assign wr_en = bus_in.wr && (bus_in.addr == RSIRQ_OFS_EN);
    assign wr_rq = bus_in.wr && (bus_in.addr == RSIRQ_OFS_RQ);

    // ----------------------------------------
    // FIFO fill count
    // ----------------------------------------
    // Push and pop together leave the count unchanged; limits guard misuse
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            fifo_fill_count_reg <= RSIRQ_RST_FILL[6:0];
        end else if (evt_in.fifo_flush) begin
            fifo_fill_count_reg <= 7'h00;
        end else if (evt_in.fifo_push && !evt_in.fifo_pop
                     && fifo_fill_count_reg < 7'(DEPTH)) begin
            fifo_fill_count_reg <= fifo_fill_count_reg + 7'h01; // RULE2
        end else if (evt_in.fifo_pop && !evt_in.fifo_push
                     && fifo_fill_count_reg != 7'h00) begin
            fifo_fill_count_reg <= fifo_fill_count_reg - 7'h01; // RULE2
        end
    end

    rsirq_alert #(
        .DEPTH(DEPTH)
    ) u_alert (
        .fill_in(fifo_fill_count_reg),
        .threshold_in(fifo_threshold_in),
        .near_full_out(near_full_now),
        .near_empty_out(near_empty_now)
    );

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            near_full_reg <= 1'b0;
            near_empty_reg <= 1'b0;
        end else begin
            near_full_reg <= near_full_now; // RULE19
            near_empty_reg <= near_empty_now; // RULE20
        end
    end

    // ----------------------------------------
    // Secondary status
    // ----------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            secondary_flags_reg <= RSIRQ_RST_SEC; // RULE7
        end else begin
            secondary_flags_reg[RSIRQ_TIMER_BIT] <= evt_in.timer_running; // RULE3
            secondary_flags_reg[RSIRQ_NVM_BIT] <= !evt_in.nvm_busy; // RULE4
            secondary_flags_reg[RSIRQ_CHECKSUM_BIT] <= !evt_in.checksum_busy; // RULE5
            secondary_flags_reg[4:3] <= 2'h0; // RULE6
            secondary_flags_reg[2:0] <= evt_in.last_bits; // RULE6
        end
    end

    // ----------------------------------------
    // Enable mask and request flags
    // ----------------------------------------
    always_comb begin
        hw_set = 6'h00;
        hw_set[RSIRQ_SRC_TIMER] = evt_in.timer_zero; // RULE11
        hw_set[RSIRQ_SRC_TX] = evt_in.tx_done; // RULE12
        hw_set[RSIRQ_SRC_RX] = evt_in.rx_done; // RULE13
        // Processor-written idle is not a completion
        hw_set[RSIRQ_SRC_IDLE] = (evt_in.cmd_idle_return && !processor_idle_cmd_in)
                                 || evt_in.cmd_unknown; // RULE14 RULE15
        // Rising edge only, so a clear sticks while the level persists
        hw_set[RSIRQ_SRC_HIGH] = near_full_now && !near_full_reg; // RULE16
        hw_set[RSIRQ_SRC_LOW] = near_empty_now && !near_empty_reg; // RULE17
    end

    always_comb begin
        irq_enable_mask_next = irq_enable_mask_reg;
        if (wr_en) begin
            irq_enable_mask_next = rsirq_mark(irq_enable_mask_reg, bus_in.wdata); // RULE8
        end
        irq_request_flags_next = irq_request_flags_reg;
        if (wr_rq) begin
            irq_request_flags_next = rsirq_mark(irq_request_flags_reg, bus_in.wdata); // RULE10
        end
        // Hardware set wins over a same-cycle clear
        irq_request_flags_next = irq_request_flags_next | hw_set; // RULE18
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_enable_mask_reg <= RSIRQ_RST_EN;
        end else begin
            irq_enable_mask_reg <= irq_enable_mask_next;
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_request_flags_reg <= RSIRQ_RST_RQ;
        end else begin
            irq_request_flags_reg <= irq_request_flags_next;
        end
    end

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------
    // Taken from next values so the pin tracks the registers exactly
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
            irq_summary_out <= 1'b0;
        end else begin
            irq_out <= |(irq_request_flags_next & irq_enable_mask_next); // RULE9 RULE22
            irq_summary_out <= |(irq_request_flags_next & irq_enable_mask_next); // RULE21
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            fifo_near_full_out <= 1'b0;
            fifo_near_empty_out <= 1'b0;
        end else begin
            fifo_near_full_out <= near_full_now;
            fifo_near_empty_out <= near_empty_now;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Data one cycle after the read strobe; unmapped reads return zero
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                RSIRQ_OFS_FILL: rdata_out <= {1'b0, fifo_fill_count_reg}; // RULE1
                RSIRQ_OFS_SEC: rdata_out <= secondary_flags_reg;
                RSIRQ_OFS_EN: rdata_out <= {2'b00, irq_enable_mask_reg};
                RSIRQ_OFS_RQ: rdata_out <= {2'b00, irq_request_flags_reg};
                default: rdata_out <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_fill_inc: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_in.fifo_push && !evt_in.fifo_pop && !evt_in.fifo_flush
        && fifo_fill_count_reg < 7'(DEPTH)
        |=> fifo_fill_count_reg == $past(fifo_fill_count_reg) + 7'h01) // RULE2
        else $error("fill count did not increment");
    a_fill_dec: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_in.fifo_pop && !evt_in.fifo_push && !evt_in.fifo_flush
        && fifo_fill_count_reg != 7'h00
        |=> fifo_fill_count_reg == $past(fifo_fill_count_reg) - 7'h01) // RULE2
        else $error("fill count did not decrement");
    a_fill_read: assert property (@(posedge clock_in) disable iff (rst_in)
        bus_in.rd && bus_in.addr == RSIRQ_OFS_FILL
        |=> rdata_out == {1'b0, $past(fifo_fill_count_reg)}) // RULE1
        else $error("fill read wrong");
    a_sec_timer: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_in.timer_running |=> secondary_flags_reg[RSIRQ_TIMER_BIT]) // RULE3
        else $error("timer flag missing");
    a_sec_ready: assert property (@(posedge clock_in) disable iff (rst_in)
        ##1 secondary_flags_reg[6:5] == ~$past({evt_in.nvm_busy, evt_in.checksum_busy})) // RULE4
        else $error("done flags wrong");
    a_en_mark: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_en |=> irq_enable_mask_reg == ($past(bus_in.wdata[7])
            ? ($past(irq_enable_mask_reg) | $past(bus_in.wdata[5:0]))
            : ($past(irq_enable_mask_reg) & ~$past(bus_in.wdata[5:0])))) // RULE8
        else $error("enable mark update wrong");
    a_rq_mark: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_rq && hw_set == 6'h00
        |=> irq_request_flags_reg == ($past(bus_in.wdata[7])
            ? ($past(irq_request_flags_reg) | $past(bus_in.wdata[5:0]))
            : ($past(irq_request_flags_reg) & ~$past(bus_in.wdata[5:0])))) // RULE10
        else $error("request mark update wrong");
    a_tx_set: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_in.tx_done |=> irq_request_flags_reg[RSIRQ_SRC_TX]) // RULE12
        else $error("transmit request lost");
    a_low_set: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(near_empty_now) |=> irq_request_flags_reg[RSIRQ_SRC_LOW]) // RULE17
        else $error("low alert request lost");
    a_rq_set_wins: assert property (@(posedge clock_in) disable iff (rst_in)
        hw_set[RSIRQ_SRC_TIMER] |=> irq_request_flags_reg[RSIRQ_SRC_TIMER]) // RULE11
        else $error("timer request lost");
    a_idle_cpu: assert property (@(posedge clock_in) disable iff (rst_in)
        evt_in.cmd_idle_return && processor_idle_cmd_in && !evt_in.cmd_unknown
        && !irq_request_flags_reg[RSIRQ_SRC_IDLE] && !wr_rq
        |=> !irq_request_flags_reg[RSIRQ_SRC_IDLE]) // RULE15
        else $error("idle request set by processor idle");
    a_alert_latch: assert property (@(posedge clock_in) disable iff (rst_in)
        irq_request_flags_reg[RSIRQ_SRC_HIGH] && !wr_rq
        |=> irq_request_flags_reg[RSIRQ_SRC_HIGH]) // RULE18
        else $error("alert request dropped");
    a_irq_pin: assert property (@(posedge clock_in) disable iff (rst_in)
        ##1 irq_out == |(irq_request_flags_reg & irq_enable_mask_reg)) // RULE22
        else $error("irq pin mismatch");
    a_sum_pin: assert property (@(posedge clock_in) disable iff (rst_in)
        ##1 irq_summary_out == |(irq_request_flags_reg & irq_enable_mask_reg)) // RULE21
        else $error("summary bit mismatch");

    c_irq_rise: cover property (@(posedge clock_in) disable iff (rst_in) $rose(irq_out));
    c_rq_clear: cover property (@(posedge clock_in) disable iff (rst_in)
        wr_rq && !bus_in.wdata[7] ##1 irq_request_flags_reg == 6'h00);
    c_near_full: cover property (@(posedge clock_in) disable iff (rst_in) $rose(near_full_reg));
    c_idle_cpu: cover property (@(posedge clock_in) disable iff (rst_in)
        evt_in.cmd_idle_return && processor_idle_cmd_in);

endmodule : rsirq_regs
`default_nettype wire

/* sim/rsirq_cpu.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Processor bus model
// ----------------------------------------
module rsirq_cpu
    import rsirq_pkg::*;
(
    input wire logic clock_in,
    input wire logic [7:0] rdata_in,
    output var rsirq_bus_s bus_out
);
    initial begin
        bus_out = '0;
    end
    // Released bus shows inverted values so stale data never looks valid
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge clock_in);
        bus_out <= '{wr: wr, rd: !wr, addr: a, wdata: wd};
        @(posedge clock_in);
        bus_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~wd};
        #1;
        rd = rdata_in;
    endtask : xfer
    // Bit 7 selects set or clear of the marked bits
    task automatic mark(input logic [7:0] a, input logic set, input logic [5:0] m);
        logic [7:0] d;
        xfer(1'b1, a, {set, 1'b0, m}, d);
    endtask : mark
endmodule : rsirq_cpu
`default_nettype wire

/* sim/rsirq_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Register and interrupt bench
// ----------------------------------------
module rsirq_regs_tb;
    import rsirq_pkg::*;
    logic clock_in;
    logic rst_in;
    rsirq_bus_s bus;
    rsirq_evt_s evt;
    rsirq_evt_s p;
    logic [7:0] thr;
    logic pidle;
    logic [7:0] rdata;
    logic irq;
    logic summ;
    logic nfull;
    logic nempty;
    logic [7:0] v;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [7:0] st_exp [3] = '{8'h85, 8'h27, 8'hE0};
    logic [5:0] st_lv [3] = '{6'h3D, 6'h17, 6'h20};
    logic [7:0] ev_exp [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h04};
    rsirq_regs #(.DEPTH(RSIRQ_FIFO_DEPTH)) DUT (
        .clock_in(clock_in), .rst_in(rst_in), .bus_in(bus), .evt_in(evt),
        .fifo_threshold_in(thr), .processor_idle_cmd_in(pidle), .rdata_out(rdata),
        .irq_out(irq), .irq_summary_out(summ), .fifo_near_full_out(nfull),
        .fifo_near_empty_out(nempty)
    );
    rsirq_cpu u_cpu (.clock_in(clock_in), .rdata_in(rdata), .bus_out(bus));
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    // Generous ceiling, the sequence needs well under a thousand cycles
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        u_cpu.xfer(1'b0, a, 8'h00, v);
        chk(nm, e, v);
    endtask : rdc
    task automatic pulse(input rsirq_evt_s q);
        @(posedge clock_in);
        evt <= evt | q;
        @(posedge clock_in);
        evt <= evt & ~q;
    endtask : pulse
    task automatic fifo(input int n, input logic pop);
        repeat (n) begin
            @(posedge clock_in);
            evt.fifo_push <= !pop;
            evt.fifo_pop <= pop;
        end
        @(posedge clock_in);
        evt.fifo_push <= 1'b0;
        evt.fifo_pop <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
    endtask : fifo
    initial begin
        rst_in = 1'b1;
        evt = '0;
        p = '0;
        thr = 8'h04;
        pidle = 1'b0;
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        rdc(RSIRQ_OFS_FILL, 8'h00, "fill");
        rdc(RSIRQ_OFS_SEC, 8'h60, "sec");
        rdc(RSIRQ_OFS_EN, 8'h00, "en");
        rdc(RSIRQ_OFS_RQ, 8'h01, "rq");
        rdc(8'h08, 8'h00, "unmapped");
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_in);
            {evt.timer_running, evt.nvm_busy, evt.checksum_busy, evt.last_bits} <= st_lv[i];
            rdc(RSIRQ_OFS_SEC, st_exp[i], "sec");
        end
        u_cpu.mark(RSIRQ_OFS_RQ, 1'b0, 6'h3F);
        rdc(RSIRQ_OFS_RQ, 8'h00, "rq");
        fifo(4, 1'b0);
        chk("near_empty", 8'h01, {7'h00, nempty});
        fifo(1, 1'b0);
        chk("near_empty", 8'h00, {7'h00, nempty});
        fifo(1, 1'b1);
        rdc(RSIRQ_OFS_RQ, 8'h01, "rq");
        fifo(1, 1'b0);
        rdc(RSIRQ_OFS_RQ, 8'h01, "rq");
        u_cpu.mark(RSIRQ_OFS_RQ, 1'b0, 6'h01);
        rdc(RSIRQ_OFS_RQ, 8'h00, "rq");
        @(posedge clock_in);
        evt.fifo_push <= 1'b1;
        evt.fifo_pop <= 1'b1;
        fifo(0, 1'b0);
        rdc(RSIRQ_OFS_FILL, 8'h05, "fill");
        fifo(54, 1'b0);
        chk("near_full", 8'h00, {7'h00, nfull});
        fifo(1, 1'b0);
        chk("near_full", 8'h01, {7'h00, nfull});
        rdc(RSIRQ_OFS_RQ, 8'h02, "rq");
        fifo(4, 1'b0);
        u_cpu.xfer(1'b1, RSIRQ_OFS_FILL, 8'h00, v);
        rdc(RSIRQ_OFS_FILL, 8'h40, "fill");
        p.fifo_flush = 1'b1;
        pulse(p);
        rdc(RSIRQ_OFS_FILL, 8'h00, "fill");
        u_cpu.xfer(1'b1, RSIRQ_OFS_EN, 8'hA3, v);
        rdc(RSIRQ_OFS_EN, 8'h23, "en");
        u_cpu.mark(RSIRQ_OFS_EN, 1'b0, 6'h01);
        rdc(RSIRQ_OFS_EN, 8'h22, "en");
        u_cpu.mark(RSIRQ_OFS_EN, 1'b0, 6'h3F);
        u_cpu.mark(RSIRQ_OFS_RQ, 1'b1, 6'h3F);
        rdc(RSIRQ_OFS_RQ, 8'h3F, "rq");
        for (int i = 0; i < 5; i++) begin
            u_cpu.mark(RSIRQ_OFS_RQ, 1'b0, 6'h3F);
            p = rsirq_evt_s'(14'h0001 << (4 - i));
            pulse(p);
            rdc(RSIRQ_OFS_RQ, ev_exp[i], "rq");
        end
        u_cpu.mark(RSIRQ_OFS_RQ, 1'b0, 6'h3F);
        @(posedge clock_in);
        pidle <= 1'b1;
        p = '0;
        p.cmd_idle_return = 1'b1;
        pulse(p);
        pidle <= 1'b0;
        rdc(RSIRQ_OFS_RQ, 8'h00, "rq");
        for (int i = 0; i < RSIRQ_SRC_COUNT; i++) begin
            u_cpu.mark(RSIRQ_OFS_RQ, 1'b1, 6'(1 << i));
            u_cpu.mark(RSIRQ_OFS_EN, 1'b1, 6'(1 << ((i + 1) % 6)));
            chk("irq", 8'h00, {7'h00, irq});
            u_cpu.mark(RSIRQ_OFS_EN, 1'b1, 6'(1 << i));
            chk("irq", 8'h01, {7'h00, irq});
            chk("summary", 8'h01, {7'h00, summ});
            u_cpu.mark(RSIRQ_OFS_RQ, 1'b0, 6'h3F);
            chk("irq", 8'h00, {7'h00, irq});
            u_cpu.mark(RSIRQ_OFS_EN, 1'b0, 6'h3F);
        end
        close_out();
    end
endmodule : rsirq_regs_tb
`default_nettype wire
